// *** rtl/byte_fifo.sv ***
// Small valid/ready buffer with synchronous flush
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic flush,
    stream_if.snk fill,
    stream_if.src drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_q, rd_q;
    logic [CW-1:0] count_q;
    logic wr_en, rd_en;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : next_ptr

    assign fill.ready = (count_q != CW'(DEPTH));
    assign drain.valid = (count_q != '0);
    assign drain.data = store[rd_q];
    assign wr_en = fill.valid & fill.ready;
    assign rd_en = drain.valid & drain.ready;

    // Flush wins over a push in the same cycle so a stale word never survives
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (wr_en) wr_q <= next_ptr(wr_q);
            if (rd_en) rd_q <= next_ptr(rd_q);
            if (wr_en && !rd_en) count_q <= count_q + CW'(1);
            else if (rd_en && !wr_en) count_q <= count_q - CW'(1);
        end
    end

    always_ff @(posedge link_clk) begin
        if (wr_en && !flush) store[wr_q] <= fill.data;
    end
endmodule : byte_fifo

// *** rtl/eeprom_pkg.sv ***
// Constants and types shared by the serial EEPROM read path and manual reset
package eeprom_pkg;
    localparam int ADDR_W = 11;
    localparam int BYTE_W = 8;
    localparam int MEM_BYTES = 2048;
    localparam logic [10:0] ADDR_TOP = 11'h7ff;
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam int TYPE_W = 4;
    localparam int SLV_TYPE_LSB = 4;
    localparam int PAGE_W = 3;
    localparam int SLV_PAGE_LSB = 1;
    localparam int SLV_RW_BIT = 0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int FIFO_DEPTH = 2;
    localparam int CLOCK_HZ = 10_000_000;
    localparam int RST_TIME_MS = 200;
    localparam int RST_CYCLES = RST_TIME_MS * (CLOCK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WADDR,
        ST_WADDR_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT_STOP
    } link_state_e;
endpackage : eeprom_pkg

// *** rtl/eeprom_read_top.sv ***
// Serial EEPROM read path on a two-wire slave link, gated by manual reset
`timescale 1ns/100ps
module eeprom_read_top #(
    parameter int RST_CYCLES = eeprom_pkg::RST_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic mr_hi_in,
    output logic mr_hi_out,
    output logic mr_hi_oe_n,
    input wire logic mr_lo_n_in,
    output logic mr_lo_n_out,
    output logic mr_lo_oe_n,
    input wire logic load_en,
    input wire logic [10:0] load_addr,
    input wire logic [7:0] load_data
);
    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int BW = eeprom_pkg::BYTE_W;
    localparam logic [10:0] ADDR_ONE = 11'h1;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // Two-wire pins and block level, synchronised into the link domain
    logic scl_m, scl_s, scl_p;
    logic sda_m, sda_s, sda_p;
    logic blk_level, blk_m, blk_s;

    // Link state
    eeprom_pkg::link_state_e state_q;
    logic [3:0] cnt_q;
    logic [BW-1:0] shift_q;
    logic [BW-1:0] tx_q;
    logic rw_q;
    logic [AW-1:0] addr_q, addr_d;
    logic [AW-1:0] pf_q;
    logic [BW-1:0] mem [eeprom_pkg::MEM_BYTES];

    // Events
    logic scl_rise, scl_fall, start_det, stop_det;
    logic byte_in_done, addr_hit, waddr_done, rd_start, next_ack, pop, flush, push;

    stream_if #(.W(BW)) fill_if ();
    stream_if #(.W(BW)) drain_if ();

    function automatic logic dev_match(input logic [7:0] b);
        return b[eeprom_pkg::SLV_TYPE_LSB +: eeprom_pkg::TYPE_W] == eeprom_pkg::DEV_TYPE;
    endfunction : dev_match

    manual_reset #(
        .CYCLES(RST_CYCLES)
    ) u_manual_reset (
        .clock(clock),
        .rst(rst),
        .hi_in(mr_hi_in),
        .lo_n_in(mr_lo_n_in),
        .hi_out(mr_hi_out),
        .hi_oe_n(mr_hi_oe_n),
        .lo_n_out(mr_lo_n_out),
        .lo_oe_n(mr_lo_oe_n),
        .mem_block(blk_level)
    );

    byte_fifo #(
        .WIDTH(BW),
        .DEPTH(eeprom_pkg::FIFO_DEPTH)
    ) u_prefetch (
        .link_clk(link_clk),
        .rst(rst),
        .flush(flush),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    // Idle bus is high; the third stage only serves edge detection
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            {scl_m, scl_s, scl_p} <= 3'h7;
            {sda_m, sda_s, sda_p} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
        end
    end

    // Block level comes from the system clock domain
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            blk_m <= 1'h0;
            blk_s <= 1'h0;
        end else begin
            blk_m <= blk_level;
            blk_s <= blk_m;
        end
    end

    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
    assign byte_in_done = scl_fall & (cnt_q == eeprom_pkg::BITS_PER_BYTE);
    // A blocked device simply does not answer its address
    assign addr_hit = (state_q == eeprom_pkg::ST_ADDR) & byte_in_done
        & dev_match(shift_q) & ~blk_s;
    assign waddr_done = (state_q == eeprom_pkg::ST_WADDR) & byte_in_done & ~blk_s;
    assign rd_start = (state_q == eeprom_pkg::ST_ADDR_ACK) & scl_fall & rw_q;
    assign next_ack = (state_q == eeprom_pkg::ST_TX_ACK) & scl_fall;
    assign pop = (rd_start | next_ack) & drain_if.valid & ~blk_s;
    // Any address load or new frame discards bytes fetched ahead
    assign flush = start_det | addr_hit | waddr_done;

    assign fill_if.valid = ~flush;
    assign fill_if.data = mem[pf_q];
    assign drain_if.ready = pop;
    assign push = fill_if.valid & fill_if.ready;

    // Link sequencer
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            state_q <= eeprom_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'h0;
        end else if (blk_s || stop_det) begin
            state_q <= eeprom_pkg::ST_IDLE;
            cnt_q <= 4'h0;
        end else if (start_det) begin
            state_q <= eeprom_pkg::ST_ADDR;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                eeprom_pkg::ST_ADDR, eeprom_pkg::ST_WADDR: begin
                    if (scl_rise && cnt_q != eeprom_pkg::BITS_PER_BYTE) begin
                        shift_q <= {shift_q[BW-2:0], sda_s};
                        cnt_q <= cnt_q + CNT_ONE;
                    end else if (byte_in_done) begin
                        cnt_q <= 4'h0;
                        if (state_q == eeprom_pkg::ST_WADDR) begin
                            state_q <= eeprom_pkg::ST_WADDR_ACK;
                        end else if (addr_hit) begin
                            state_q <= eeprom_pkg::ST_ADDR_ACK;
                            rw_q <= shift_q[eeprom_pkg::SLV_RW_BIT];
                        end else begin
                            state_q <= eeprom_pkg::ST_IDLE;
                        end
                    end
                end
                eeprom_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (pop) begin
                            state_q <= eeprom_pkg::ST_TX;
                            tx_q <= {drain_if.data[BW-2:0], 1'h0};
                            cnt_q <= CNT_ONE;
                        end else if (rw_q) begin
                            state_q <= eeprom_pkg::ST_WAIT_STOP;
                        end else begin
                            state_q <= eeprom_pkg::ST_WADDR;
                            cnt_q <= 4'h0;
                        end
                    end
                end
                eeprom_pkg::ST_WADDR_ACK: begin
                    // Write data is not supported; master repeats START to read
                    if (scl_fall) state_q <= eeprom_pkg::ST_WAIT_STOP;
                end
                eeprom_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q != eeprom_pkg::BITS_PER_BYTE) begin
                            tx_q <= {tx_q[BW-2:0], 1'h0};
                            cnt_q <= cnt_q + CNT_ONE;
                        end else begin
                            state_q <= eeprom_pkg::ST_TX_ACK;
                        end
                    end
                end
                eeprom_pkg::ST_TX_ACK: begin
                    if (scl_rise && sda_s) begin
                        state_q <= eeprom_pkg::ST_WAIT_STOP;
                    end else if (scl_fall) begin
                        if (pop) begin
                            state_q <= eeprom_pkg::ST_TX;
                            tx_q <= {drain_if.data[BW-2:0], 1'h0};
                            cnt_q <= CNT_ONE;
                        end else begin
                            state_q <= eeprom_pkg::ST_WAIT_STOP;
                        end
                    end
                end
                eeprom_pkg::ST_IDLE, eeprom_pkg::ST_WAIT_STOP: begin
                    cnt_q <= 4'h0;
                end
                default: begin
                    state_q <= eeprom_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data line drive: open drain, driven only after SCL falls; released also on START, STOP or block
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            sda_oe_n <= 1'h1;
        end else if (blk_s || start_det || stop_det) begin
            sda_oe_n <= 1'h1;
        end else if (addr_hit || waddr_done) begin
            sda_oe_n <= 1'h0;
        end else if (pop) begin
            sda_oe_n <= drain_if.data[BW-1];
        end else if (scl_fall && state_q == eeprom_pkg::ST_TX
            && cnt_q != eeprom_pkg::BITS_PER_BYTE) begin
            sda_oe_n <= tx_q[BW-1];
        end else if (scl_fall && (state_q == eeprom_pkg::ST_ADDR_ACK
            || state_q == eeprom_pkg::ST_WADDR_ACK || state_q == eeprom_pkg::ST_TX
            || state_q == eeprom_pkg::ST_TX_ACK)) begin
            sda_oe_n <= 1'h1;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) sda_out <= 1'h0;
        else sda_out <= 1'h0;
    end

    // Address counter: page bits from the slave byte, low byte from the dummy write
    always_comb begin
        addr_d = addr_q;
        if (addr_hit) begin
            addr_d[AW-1 -: eeprom_pkg::PAGE_W] =
                shift_q[eeprom_pkg::SLV_PAGE_LSB +: eeprom_pkg::PAGE_W];
        end else if (waddr_done) begin
            addr_d[BW-1:0] = shift_q;
        end else if (pop) begin
            addr_d = addr_q + ADDR_ONE;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) addr_q <= '0;
        else addr_q <= addr_d;
    end

    // Prefetch pointer runs ahead of the counter by the buffered words
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) pf_q <= '0;
        else if (flush) pf_q <= addr_d;
        else if (push) pf_q <= pf_q + ADDR_ONE;
    end

    // Preload port stands in for the write path, which this block omits
    always_ff @(posedge link_clk) begin
        if (load_en) mem[load_addr] <= load_data;
    end

    property p_ack_addr;
        @(posedge link_clk) disable iff (rst)
        addr_hit |=> (!sda_oe_n && state_q == eeprom_pkg::ST_ADDR_ACK);
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("address not acked");

    property p_first_byte;
        @(posedge link_clk) disable iff (rst)
        (rd_start && drain_if.valid && !blk_s)
            |=> (state_q == eeprom_pkg::ST_TX && sda_oe_n == $past(drain_if.data[BW-1]));
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("read byte not sent");

    property p_blocked;
        @(posedge link_clk) disable iff (rst)
        blk_s |=> (sda_oe_n && state_q == eeprom_pkg::ST_IDLE);
    endproperty
    a_blocked: assert property (p_blocked) else $error("drive while blocked");

    property p_incr;
        @(posedge link_clk) disable iff (rst)
        pop |=> (addr_q == $past(addr_q) + ADDR_ONE);
    endproperty
    a_incr: assert property (p_incr) else $error("counter not advanced");

    property p_wrap;
        @(posedge link_clk) disable iff (rst)
        (pop && addr_q == eeprom_pkg::ADDR_TOP) |=> (addr_q == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_low_load;
        @(posedge link_clk) disable iff (rst)
        waddr_done |=> (addr_q[BW-1:0] == $past(shift_q) && !sda_oe_n);
    endproperty
    a_low_load: assert property (p_low_load) else $error("byte address lost");

    property p_nack_stop;
        @(posedge link_clk) disable iff (rst)
        (state_q == eeprom_pkg::ST_TX_ACK && scl_rise && sda_s && !blk_s && !stop_det
            && !start_det) |=> (state_q == eeprom_pkg::ST_WAIT_STOP) ##1 sda_oe_n;
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("sent after NACK");

    property p_next_byte;
        @(posedge link_clk) disable iff (rst)
        (next_ack && pop) |=> (state_q == eeprom_pkg::ST_TX && cnt_q == CNT_ONE);
    endproperty
    a_next_byte: assert property (p_next_byte) else $error("no byte after ACK");

    property p_foreign;
        @(posedge link_clk) disable iff (rst)
        (state_q == eeprom_pkg::ST_ADDR && byte_in_done && !start_det && !stop_det
            && shift_q[eeprom_pkg::SLV_TYPE_LSB +: eeprom_pkg::TYPE_W] != eeprom_pkg::DEV_TYPE)
            |=> (state_q == eeprom_pkg::ST_IDLE && sda_oe_n);
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address acked");

    property p_start_addr;
        @(posedge link_clk) disable iff (rst)
        (start_det && !blk_s)
            |=> (state_q == eeprom_pkg::ST_ADDR && cnt_q == 4'h0 && sda_oe_n);
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_stop_idle;
        @(posedge link_clk) disable iff (rst)
        stop_det |=> (state_q == eeprom_pkg::ST_IDLE && sda_oe_n);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

    property p_page_load;
        @(posedge link_clk) disable iff (rst)
        addr_hit |=> (addr_q[AW-1 -: eeprom_pkg::PAGE_W]
            == $past(shift_q[eeprom_pkg::SLV_PAGE_LSB +: eeprom_pkg::PAGE_W]));
    endproperty
    a_page_load: assert property (p_page_load) else $error("page bits lost");

    // A data change while SCL is high would read as START or STOP on the bus
    property p_sda_stable;
        @(posedge link_clk) disable iff (rst)
        (scl_s && scl_p && !start_det && !stop_det && !blk_s) |=> $stable(sda_oe_n);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");

    property p_waddr_release;
        @(posedge link_clk) disable iff (rst)
        (state_q == eeprom_pkg::ST_ADDR_ACK && scl_fall && !pop && !blk_s)
            |=> sda_oe_n;
    endproperty
    a_waddr_release: assert property (p_waddr_release) else $error("ack not released");
endmodule : eeprom_read_top

// *** rtl/manual_reset.sv ***
// Manual reset edge sensing, fixed-length complementary pulse and memory block level
`timescale 1ns/100ps
module manual_reset #(
    parameter int CYCLES = eeprom_pkg::RST_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic hi_in,
    input wire logic lo_n_in,
    output logic hi_out,
    output logic hi_oe_n,
    output logic lo_n_out,
    output logic lo_oe_n,
    output logic mem_block
);
    localparam int CW = $clog2(CYCLES + 1);

    logic hi_m, hi_s, hi_p, lo_m, lo_s, lo_p;
    logic [CW-1:0] left_q;
    logic busy, hi_edge, lo_edge;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {hi_m, hi_s, hi_p} <= 3'h0;
            {lo_m, lo_s, lo_p} <= 3'h7;
        end else begin
            {hi_m, hi_s, hi_p} <= {hi_in, hi_m, hi_s};
            {lo_m, lo_s, lo_p} <= {lo_n_in, lo_m, lo_s};
        end
    end

    assign busy = (left_q != '0);
    assign hi_edge = hi_s & ~hi_p;
    assign lo_edge = ~lo_s & lo_p;

    // Edges during the pulse are ignored: our own drive would otherwise retrigger
    always_ff @(posedge clock or posedge rst) begin
        if (rst) left_q <= '0;
        else if ((hi_edge || lo_edge) && !busy) left_q <= CW'(CYCLES);
        else if (busy) left_q <= left_q - CW'(1);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hi_out <= 1'h0;
            hi_oe_n <= 1'h1;
            lo_n_out <= 1'h1;
            lo_oe_n <= 1'h1;
        end else if (hi_edge && !busy) begin
            lo_n_out <= 1'h0;
            lo_oe_n <= 1'h0;
        end else if (lo_edge && !busy) begin
            hi_out <= 1'h1;
            hi_oe_n <= 1'h0;
        end else if (left_q == CW'(1)) begin
            hi_out <= 1'h0;
            hi_oe_n <= 1'h1;
            lo_n_out <= 1'h1;
            lo_oe_n <= 1'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) mem_block <= 1'h0;
        else mem_block <= busy | hi_s | ~lo_s;
    end

    property p_pulse_start;
        @(posedge clock) disable iff (rst)
        (hi_edge && !busy) |=> (!lo_oe_n && !lo_n_out && left_q == CW'(CYCLES));
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

    property p_pulse_end;
        @(posedge clock) disable iff (rst)
        (left_q == CW'(1)) |=> (hi_oe_n && lo_oe_n && left_q == '0);
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse not ended");

    property p_edge_only;
        @(posedge clock) disable iff (rst)
        (!busy && !hi_edge && !lo_edge) |=> (left_q == '0);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("count without edge");

    property p_held_block;
        @(posedge clock) disable iff (rst)
        (hi_s || !lo_s) |=> mem_block;
    endproperty
    a_held_block: assert property (p_held_block) else $error("memory not blocked");
endmodule : manual_reset

// *** rtl/stream_if.sv ***
// Valid/ready byte stream between the read path and its buffer
`timescale 1ns/100ps
interface stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

// *** sim/serial_eeprom_read_manual_reset_tb.sv ***
// Self-checking bench for the EEPROM read path and manual reset
`timescale 1ns/100ps
module serial_eeprom_read_manual_reset_tb;
    localparam int RST_SIM = 200;
    logic clock, rst, link_clk, load_en, hi_press, lo_press, scl, sda_pull;
    logic sda_out, sda_oe_n, mr_hi_out, mr_hi_oe_n, mr_lo_n_out, mr_lo_oe_n;
    logic [10:0] load_addr, cur;
    logic [7:0] load_data;
    logic [7:0] mem [0:2047];
    logic [31:0] seed_val;
    int len;
    int err_count = 0;
    int total_checks = 0;
    wire logic sda_w, mr_hi_w, mr_lo_n_w;

    // Pull-up on SDA and the low pin, pull-down on the high pin
    assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & ~sda_pull;
    assign mr_hi_w = hi_press | (~mr_hi_oe_n & mr_hi_out);
    assign mr_lo_n_w = ~lo_press & (mr_lo_oe_n | mr_lo_n_out);

    eeprom_read_top #(.RST_CYCLES(RST_SIM)) DUT (
        .clock(clock), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .mr_hi_in(mr_hi_w),
        .mr_hi_out(mr_hi_out), .mr_hi_oe_n(mr_hi_oe_n), .mr_lo_n_in(mr_lo_n_w),
        .mr_lo_n_out(mr_lo_n_out), .mr_lo_oe_n(mr_lo_oe_n), .load_en(load_en),
        .load_addr(load_addr), .load_data(load_data)
    );

    two_wire_master mst (.scl(scl), .sda_pull(sda_pull), .sda(sda_w));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %0h exp %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [10:0] next_addr(input logic [10:0] a);
        return (a == 11'h7ff) ? 11'h000 : a + 11'h001;
    endfunction : next_addr

    task automatic addr_byte(input logic [3:0] dt, input logic [2:0] pg, input logic rd,
                             input logic ack);
        logic [8:0] rx;
        mst.shift9({dt, pg, rd, 1'b1}, rx);
        check(rx[0], !ack, "address ack");
    endtask : addr_byte

    // Blocked or foreign frames must not load the counter, so the probe keeps its page
    task automatic probe(input logic [3:0] dt);
        mst.start_cond();
        addr_byte(dt, cur[10:8], 1'b1, 1'b0);
        mst.stop_cond();
    endtask : probe

    task automatic read_seq(input logic [10:0] a0, input int n, input logic rnd);
        logic [8:0] rx;
        logic [10:0] a;
        a = rnd ? a0 : cur;
        mst.start_cond();
        if (rnd) begin
            addr_byte(eeprom_pkg::DEV_TYPE, a[10:8], 1'b0, 1'b1);
            mst.shift9({a[7:0], 1'b1}, rx);
            check(rx[0], 1'b0, "byte address ack");
            mst.start_cond();
        end
        addr_byte(eeprom_pkg::DEV_TYPE, a[10:8], 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            mst.shift9({8'hff, i == n - 1}, rx);
            check(rx[8:1], mem[a], "read data");
            a = next_addr(a);
        end
        #200;
        check(sda_oe_n, 1'b1, "released after nack");
        mst.stop_cond();
        cur = a;
    endtask : read_seq

    task automatic pulse_len(input logic hi_pin);
        int guard;
        guard = 0;
        len = 0;
        while ((hi_pin ? mr_hi_oe_n : mr_lo_oe_n) !== 1'b0 && guard < 10) begin
            @(negedge clock);
            guard++;
        end
        // The driven level counts as part of the pulse, so a wrong level shortens it to nothing
        while ((hi_pin ? {mr_hi_oe_n, mr_hi_out} : {mr_lo_oe_n, mr_lo_n_out})
               === (hi_pin ? 2'b01 : 2'b00) && len < RST_SIM + 50) begin
            @(negedge clock);
            len++;
        end
    endtask : pulse_len

    initial begin
        #2_000_000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        load_en = 1'b0;
        load_addr = 11'h000;
        load_data = 8'h00;
        hi_press = 1'b0;
        lo_press = 1'b0;
        cur = 11'h000;
        seed_val = $urandom(98);
        repeat (6) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 2048; i++) begin
            @(negedge link_clk);
            load_en = 1'b1;
            load_addr = i[10:0];
            load_data = 8'($urandom);
            mem[i] = load_data;
        end
        @(negedge link_clk);
        load_en = 1'b0;
        #1000;
        read_seq(11'h000, 2, 1'b0);
        $display("test current_read done");
        for (int k = 0; k < 4; k++) begin
            read_seq(11'($urandom), 1 + ($urandom % 3), 1'b1);
            read_seq(11'h000, 2, 1'b0);
        end
        $display("test random_read done");
        read_seq(11'h7fe, 3, 1'b1);
        read_seq(11'h7ff, 1, 1'b1);
        read_seq(11'h000, 1, 1'b0);
        probe(4'h5);
        $display("test wrap_and_type done");
        // Button held well past the pulse: the pulse still ends on time
        @(negedge clock);
        hi_press = 1'b1;
        pulse_len(1'b0);
        check(len, RST_SIM, "pulse length");
        probe(eeprom_pkg::DEV_TYPE);
        @(negedge clock);
        hi_press = 1'b0;
        repeat (10) @(negedge clock);
        check(mr_lo_oe_n, 1'b1, "inactive edge");
        read_seq(11'h000, 1, 1'b0);
        $display("test manual_reset_high done");
        @(negedge clock);
        lo_press = 1'b1;
        repeat (2) @(negedge clock);
        lo_press = 1'b0;
        repeat (6) @(negedge clock);
        check({mr_hi_oe_n, mr_hi_out}, 2'b01, "high pin driven");
        probe(eeprom_pkg::DEV_TYPE);
        pulse_len(1'b1);
        check(mr_hi_oe_n, 1'b1, "high pin released");
        repeat (10) @(negedge clock);
        read_seq(11'h000, 2, 1'b0);
        $display("test manual_reset_low done");
        give_verdict();
    end
endmodule : serial_eeprom_read_manual_reset_tb

// *** sim/two_wire_master.sv ***
// Behavioural two-wire bus master that clocks SCL and pulls SDA
`timescale 1ns/100ps
module two_wire_master #(
    parameter int HALF_NS = 480
) (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Works from idle and as a repeated start; SCL then stays low
    task automatic start_cond();
        #(HALF_NS / 2) sda_pull = 1'b0;
        #(HALF_NS / 2) scl = 1'b1;
        #(HALF_NS / 2) sda_pull = 1'b1;
        #(HALF_NS / 2) scl = 1'b0;
    endtask : start_cond

    // SCL is left high afterwards, so the clock stands still between frames
    task automatic stop_cond();
        #(HALF_NS / 2) sda_pull = 1'b1;
        #(HALF_NS / 2) scl = 1'b1;
        #(HALF_NS / 2) sda_pull = 1'b0;
        #(HALF_NS / 2);
    endtask : stop_cond

    // Nine clocks, MSB first; a 1 in tx releases SDA so the device may answer
    task automatic shift9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #(HALF_NS / 4) sda_pull = ~tx[i];
            #(HALF_NS * 3 / 4) scl = 1'b1;
            #(HALF_NS / 2) rx[i] = sda;
            #(HALF_NS / 2) scl = 1'b0;
        end
    endtask : shift9
endmodule : two_wire_master
